// ===== hdl/ifd_decode.sv
`timescale 1ns/1ps
// Operation
// RULE1 - every instruction is one 14-bit word split into opcode and operands
// RULE2 - byte ops: dest 0 writes accumulator, dest 1 writes the file register
// RULE3 - byte ops: file address field picks the source file register
// RULE4 - file address field spans 0x00 to 0x7F, 128 locations
// RULE5 - bit ops: bit field picks one of eight bits of the file register
// RULE6 - literal and control ops: extract an 8- or 11-bit literal
// RULE7 - don't-care bits decode the same whether zero or one
// RULE8 - one cycle each; taken skip or branch adds a NOP second cycle
// RULE9 - one instruction cycle is four oscillator periods, four phases
// RULE10 - field positions follow the fixed instruction format layouts
module ifd_decode (
	input  wire logic                    i_clk,
	input  wire logic                    i_nrst,
	input  wire logic [13:0]             i_instr,
	input  wire logic                    i_skip_true,
	output logic      [1:0]              o_phase,
	output logic                         o_fetch,
	output logic                         o_nop_cycle,
	output ifd_pkg::ifd_dec_t            o_dec
);

	// full decode of one word
	function automatic ifd_pkg::ifd_dec_t fn_decode(input logic [13:0] w);
		ifd_pkg::ifd_dec_t d;
		d = '0;
		d.op     = ifd_pkg::IFD_OP_BAD;
		d.dest   = w[ifd_pkg::DEST_POS];                                    // [RULE2] [RULE10]
		d.faddr  = w[ifd_pkg::FADDR_LSB +: ifd_pkg::FADDR_W];               // [RULE3] [RULE4]
		d.bitsel = w[ifd_pkg::BITSEL_LSB +: ifd_pkg::BITSEL_W];             // [RULE5]
		d.lit8   = w[ifd_pkg::LIT_LSB +: ifd_pkg::LIT8_W];                  // [RULE6]
		d.lit11  = w[ifd_pkg::LIT_LSB +: ifd_pkg::LIT11_W];                 // [RULE6]
		case (w[ifd_pkg::CLASS_LSB +: 2])                                   // [RULE1]
			2'h0: begin
				case (w[ifd_pkg::BYTE_OP_LSB +: 4])
					4'h0: begin
						if (w[ifd_pkg::DEST_POS])
							d.op = ifd_pkg::IFD_OP_STORE_W;
						else if (w == ifd_pkg::W_RETURN)
							d.op = ifd_pkg::IFD_OP_RET;
						else if (w == ifd_pkg::W_RETI)
							d.op = ifd_pkg::IFD_OP_RETI;
						else if (w == ifd_pkg::W_SLEEP)
							d.op = ifd_pkg::IFD_OP_SLEEP;
						else if (w == ifd_pkg::W_CLRDOG)
							d.op = ifd_pkg::IFD_OP_CLR_DOG;
						else if (w[4:0] == 5'h00)
							d.op = ifd_pkg::IFD_OP_NOP;                     // [RULE7] bits 6:5 free
					end
					4'h1: d.op = w[ifd_pkg::DEST_POS] ? ifd_pkg::IFD_OP_CLR_F
						: ifd_pkg::IFD_OP_CLR_W;                            // [RULE7] bits 6:0 free
					4'h2: d.op = ifd_pkg::IFD_OP_SUB_F;
					4'h3: d.op = ifd_pkg::IFD_OP_DEC_F;
					4'h4: d.op = ifd_pkg::IFD_OP_OR_F;
					4'h5: d.op = ifd_pkg::IFD_OP_AND_F;
					4'h6: d.op = ifd_pkg::IFD_OP_XOR_F;
					4'h7: d.op = ifd_pkg::IFD_OP_ADD_F;
					4'h8: d.op = ifd_pkg::IFD_OP_MOVE_F;
					4'h9: d.op = ifd_pkg::IFD_OP_INV_F;
					4'ha: d.op = ifd_pkg::IFD_OP_INC_F;
					4'hb: d.op = ifd_pkg::IFD_OP_DEC_SKIP;
					4'hc: d.op = ifd_pkg::IFD_OP_ROT_R;
					4'hd: d.op = ifd_pkg::IFD_OP_ROT_L;
					4'he: d.op = ifd_pkg::IFD_OP_NIB_SWAP;
					default: d.op = ifd_pkg::IFD_OP_INC_SKIP;
				endcase
			end
			2'h1: begin
				case (w[ifd_pkg::BIT_OP_LSB +: 2])
					2'h0: d.op = ifd_pkg::IFD_OP_BIT_CLR;
					2'h1: d.op = ifd_pkg::IFD_OP_BIT_SET;
					2'h2: d.op = ifd_pkg::IFD_OP_SKIP_CLR;
					default: d.op = ifd_pkg::IFD_OP_SKIP_SET;
				endcase
			end
			2'h2: d.op = w[ifd_pkg::JUMP_SEL] ? ifd_pkg::IFD_OP_JUMP : ifd_pkg::IFD_OP_CALL;
			default: begin
				case (w[11:10])
					2'h0: d.op = ifd_pkg::IFD_OP_LOAD_LIT;                  // [RULE7] bits 9:8 free
					2'h1: d.op = ifd_pkg::IFD_OP_RET_LIT;                   // [RULE7] bits 9:8 free
					2'h2: begin
						if (w[9:8] == 2'h0)
							d.op = ifd_pkg::IFD_OP_OR_LIT;
						else if (w[9:8] == 2'h1)
							d.op = ifd_pkg::IFD_OP_AND_LIT;
						else if (w[9:8] == 2'h2)
							d.op = ifd_pkg::IFD_OP_XOR_LIT;
					end
					default: d.op = w[9] ? ifd_pkg::IFD_OP_ADD_LIT
						: ifd_pkg::IFD_OP_SUB_LIT;                          // [RULE7] bit 8 free
				endcase
			end
		endcase
		d.is_branch = (d.op == ifd_pkg::IFD_OP_CALL) || (d.op == ifd_pkg::IFD_OP_JUMP)
			|| (d.op == ifd_pkg::IFD_OP_RET) || (d.op == ifd_pkg::IFD_OP_RETI)
			|| (d.op == ifd_pkg::IFD_OP_RET_LIT);
		d.is_skip = (d.op == ifd_pkg::IFD_OP_DEC_SKIP) || (d.op == ifd_pkg::IFD_OP_INC_SKIP)
			|| (d.op == ifd_pkg::IFD_OP_SKIP_CLR) || (d.op == ifd_pkg::IFD_OP_SKIP_SET);
		return d;
	endfunction

	// decoded forced no-operation for the second cycle
	function automatic ifd_pkg::ifd_dec_t fn_nop();
		ifd_pkg::ifd_dec_t d;
		d = '0;
		d.op = ifd_pkg::IFD_OP_NOP;
		return d;
	endfunction

	typedef struct packed {
		logic [1:0]        phase;
		logic              fetch;
		logic              nop_cycle;
		ifd_pkg::ifd_dec_t dec;
	} ifd_state_t;

	logic       [1:0] rst_sync;
	logic             nrst;
	ifd_state_t       st;
	ifd_state_t       next_st;

	// reset release through two flops
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign nrst = rst_sync[1];

	// phase sequencer and instruction latch
	always_comb begin
		next_st = st;
		next_st.phase = st.phase + 2'h1;                                    // [RULE9]
		next_st.fetch = (st.phase == ifd_pkg::PHASE_END);
		if (st.phase == ifd_pkg::PHASE_END) begin
			if (!st.nop_cycle && (st.dec.is_branch || (st.dec.is_skip && i_skip_true))) begin
				next_st.dec       = fn_nop();                               // [RULE8]
				next_st.nop_cycle = 1'b1;
			end else begin
				next_st.dec       = fn_decode(i_instr);                     // [RULE1]
				next_st.nop_cycle = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge i_clk or negedge nrst) begin
		if (!nrst) begin
			st       <= '0;
			st.phase <= ifd_pkg::PHASE_RST;
			st.dec.op <= ifd_pkg::IFD_OP_NOP;                               // idle decode is a nop
		end else begin
			st <= next_st;
		end
	end

	assign o_phase     = st.phase;
	assign o_fetch     = st.fetch;
	assign o_nop_cycle = st.nop_cycle;
	assign o_dec       = st.dec;

	// helper copies for checking
	logic [13:0] chk_word;
	logic        chk_take;
	always_ff @(posedge i_clk or negedge nrst) begin
		if (!nrst) begin
			chk_word <= 14'h0000;
			chk_take <= 1'b0;
		end else begin
			chk_word <= i_instr;
			chk_take <= (st.phase == ifd_pkg::PHASE_END) && !next_st.nop_cycle;
		end
	end

	AST_PHASE_STEP: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE9]
		o_phase == $past(o_phase) + 2'h1 || !$past(nrst))
		else $error("phase did not advance by one");
	AST_DEC_HOLD: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE9]
		(o_phase != 2'h0) |-> $stable(o_dec))
		else $error("decode changed inside an instruction cycle");
	AST_FLUSH_AFTER_BRANCH: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE8]
		(o_phase == 2'h3 && o_dec.is_branch && !o_nop_cycle)
		|=> (o_nop_cycle && o_dec.op == ifd_pkg::IFD_OP_NOP) [*4])
		else $error("branch not followed by four-clock NOP cycle");
	AST_SKIP_TAKEN: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE8]
		(o_phase == 2'h3 && o_dec.is_skip && i_skip_true && !o_nop_cycle) |=> o_nop_cycle)
		else $error("taken skip did not insert NOP cycle");
	AST_NO_FLUSH_PLAIN: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE8]
		(o_phase == 2'h3 && !o_dec.is_branch && !o_dec.is_skip) |=> !o_nop_cycle)
		else $error("plain instruction took two cycles");
	AST_FIELDS: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE3]
		chk_take |-> (o_dec.faddr == chk_word[6:0] && o_dec.dest == chk_word[7]
		&& o_dec.bitsel == chk_word[9:7]))
		else $error("file, dest or bit field wrong");
	AST_LITERALS: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE6]
		chk_take |-> (o_dec.lit8 == chk_word[7:0] && o_dec.lit11 == chk_word[10:0]))
		else $error("literal field wrong");
	AST_DONT_CARE: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE7]
		(chk_take && chk_word[13:10] == 4'hc) |-> o_dec.op == ifd_pkg::IFD_OP_LOAD_LIT)
		else $error("don't-care bits changed the decode");
	AST_FETCH_PULSE: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE9]
		o_fetch |-> (o_phase == 2'h0 ##1 !o_fetch [*3]))
		else $error("fetch pulse not once per four clocks");

	// an untaken skip and a forced nop both run as single cycles
	AST_SKIP_PLAIN: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE8]
		(o_phase == 2'h3 && o_dec.is_skip && !i_skip_true && !o_nop_cycle) |=> !o_nop_cycle)
		else $error("untaken skip inserted NOP cycle");
	AST_NOP_ONCE: assert property (@(posedge i_clk) disable iff (!nrst) // [RULE8]
		(o_phase == 2'h3 && o_nop_cycle) |=> !o_nop_cycle)
		else $error("forced NOP cycle repeated");

	COV_BRANCH: cover property (@(posedge i_clk) disable iff (!nrst)
		o_phase == 2'h3 && o_dec.op == ifd_pkg::IFD_OP_JUMP);
	COV_SKIP: cover property (@(posedge i_clk) disable iff (!nrst)
		o_phase == 2'h3 && o_dec.is_skip && i_skip_true);
	COV_BYTE_DEST: cover property (@(posedge i_clk) disable iff (!nrst)
		chk_take && o_dec.op == ifd_pkg::IFD_OP_ADD_F && o_dec.dest);
	COV_SKIP_PLAIN: cover property (@(posedge i_clk) disable iff (!nrst)
		o_phase == 2'h3 && o_dec.is_skip && !i_skip_true);

endmodule

// ===== include/ifd_pkg.sv
package ifd_pkg;

	// instruction word and field geometry
	localparam int INSTR_W     = 14;
	localparam int FADDR_W     = 7;
	localparam int BITSEL_W    = 3;
	localparam int LIT8_W      = 8;
	localparam int LIT11_W     = 11;
	localparam int PHASES      = 4;
	localparam int PHASE_W     = 2;

	// field positions inside the word
	localparam int CLASS_LSB   = 12;
	localparam int BYTE_OP_LSB = 8;
	localparam int DEST_POS    = 7;
	localparam int FADDR_LSB   = 0;
	localparam int BITSEL_LSB  = 7;
	localparam int BIT_OP_LSB  = 10;
	localparam int LIT_LSB     = 0;
	localparam int JUMP_SEL    = 11;

	// fully fixed control words
	localparam logic [13:0] W_RETURN = 14'h0008;
	localparam logic [13:0] W_RETI   = 14'h0009;
	localparam logic [13:0] W_SLEEP  = 14'h0063;
	localparam logic [13:0] W_CLRDOG = 14'h0064;

	// reset phase and last phase values
	localparam logic [1:0]  PHASE_RST = 2'h0;
	localparam logic [1:0]  PHASE_END = 2'h3;

	typedef enum logic [5:0] {
		IFD_OP_NOP, IFD_OP_STORE_W, IFD_OP_CLR_F, IFD_OP_CLR_W, IFD_OP_SUB_F,
		IFD_OP_DEC_F, IFD_OP_OR_F, IFD_OP_AND_F, IFD_OP_XOR_F, IFD_OP_ADD_F,
		IFD_OP_MOVE_F, IFD_OP_INV_F, IFD_OP_INC_F, IFD_OP_DEC_SKIP, IFD_OP_ROT_R,
		IFD_OP_ROT_L, IFD_OP_NIB_SWAP, IFD_OP_INC_SKIP, IFD_OP_BIT_CLR,
		IFD_OP_BIT_SET, IFD_OP_SKIP_CLR, IFD_OP_SKIP_SET, IFD_OP_CALL,
		IFD_OP_JUMP, IFD_OP_RET, IFD_OP_RETI, IFD_OP_RET_LIT, IFD_OP_LOAD_LIT,
		IFD_OP_OR_LIT, IFD_OP_AND_LIT, IFD_OP_XOR_LIT, IFD_OP_ADD_LIT,
		IFD_OP_SUB_LIT, IFD_OP_SLEEP, IFD_OP_CLR_DOG, IFD_OP_BAD
	} ifd_op_t;

	typedef struct packed {
		ifd_op_t             op;
		logic                dest;
		logic [FADDR_W-1:0]  faddr;
		logic [BITSEL_W-1:0] bitsel;
		logic [LIT8_W-1:0]   lit8;
		logic [LIT11_W-1:0]  lit11;
		logic                is_branch;
		logic                is_skip;
	} ifd_dec_t;

endpackage

// ===== sim/ifd_decode_test.sv
`timescale 1ns/1ps
module ifd_decode_test;
	logic              i_clk;
	logic              i_nrst;
	logic [13:0]       i_instr;
	logic              i_skip_true;
	logic [1:0]        o_phase;
	logic              o_fetch;
	logic              o_nop_cycle;
	ifd_pkg::ifd_dec_t o_dec;
	ifd_pkg::ifd_dec_t held;
	int                errors;
	int                total_checks;
	logic              nop_due;
	ifd_pkg::ifd_op_t  last_op;
	logic [13:0]       w;
	// a filler word follows each op that flushes, since that word is dropped
	logic [13:0]       corner [16] = '{14'h0000, 14'h0060, 14'h0008, 14'h0000, 14'h0009,
		14'h0000, 14'h0063, 14'h0064, 14'h0062, 14'h3B00, 14'h3300, 14'h017F, 14'h0BFF,
		14'h0000, 14'h2FFF, 14'h0000};

	ifd_decode u_ifd_decode (
		.i_clk       (i_clk),
		.i_nrst      (i_nrst),
		.i_instr     (i_instr),
		.i_skip_true (i_skip_true),
		.o_phase     (o_phase),
		.o_fetch     (o_fetch),
		.o_nop_cycle (o_nop_cycle),
		.o_dec       (o_dec)
	);

	// oscillator clock
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	task chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	task end_sim;
		if (errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// expected operation from the word alone
	function automatic ifd_pkg::ifd_op_t exp_op(input logic [13:0] x);
		case (x[13:12])
			2'h0: begin
				if (x[11:8] == 4'h1) return x[7] ? ifd_pkg::IFD_OP_CLR_F : ifd_pkg::IFD_OP_CLR_W;
				if (x[11:8] != 4'h0) return ifd_pkg::ifd_op_t'(6'(x[11:8]) + 6'h02);
				if (x[7]) return ifd_pkg::IFD_OP_STORE_W;
				case (x)
					14'h0008: return ifd_pkg::IFD_OP_RET;
					14'h0009: return ifd_pkg::IFD_OP_RETI;
					14'h0063: return ifd_pkg::IFD_OP_SLEEP;
					14'h0064: return ifd_pkg::IFD_OP_CLR_DOG;
					14'h0000, 14'h0020, 14'h0040, 14'h0060: return ifd_pkg::IFD_OP_NOP;
					default: return ifd_pkg::IFD_OP_BAD;
				endcase
			end
			2'h1: return ifd_pkg::ifd_op_t'(6'(x[11:10]) + 6'h12);
			2'h2: return x[11] ? ifd_pkg::IFD_OP_JUMP : ifd_pkg::IFD_OP_CALL;
			default: begin
				case (x[11:8])
					4'h0, 4'h1, 4'h2, 4'h3: return ifd_pkg::IFD_OP_LOAD_LIT;
					4'h4, 4'h5, 4'h6, 4'h7: return ifd_pkg::IFD_OP_RET_LIT;
					4'h8: return ifd_pkg::IFD_OP_OR_LIT;
					4'h9: return ifd_pkg::IFD_OP_AND_LIT;
					4'hA: return ifd_pkg::IFD_OP_XOR_LIT;
					4'hB: return ifd_pkg::IFD_OP_BAD;
					4'hC, 4'hD: return ifd_pkg::IFD_OP_SUB_LIT;
					default: return ifd_pkg::IFD_OP_ADD_LIT;
				endcase
			end
		endcase
	endfunction

	// ops that load the program counter and so flush the next fetch
	function automatic logic is_pc_op(input ifd_pkg::ifd_op_t o);
		return o inside {ifd_pkg::IFD_OP_CALL, ifd_pkg::IFD_OP_JUMP, ifd_pkg::IFD_OP_RET,
			ifd_pkg::IFD_OP_RETI, ifd_pkg::IFD_OP_RET_LIT};
	endfunction

	// conditional skip ops
	function automatic logic is_skip_op(input ifd_pkg::ifd_op_t o);
		return o inside {ifd_pkg::IFD_OP_DEC_SKIP, ifd_pkg::IFD_OP_INC_SKIP,
			ifd_pkg::IFD_OP_SKIP_CLR, ifd_pkg::IFD_OP_SKIP_SET};
	endfunction

	// one instruction cycle: offer x at phase 3, s answers the skip now executing
	task issue(input logic [13:0] x, input logic s);
		ifd_pkg::ifd_op_t op;
		int               n;
		n = 0;
		while (o_phase !== 2'h3) begin
			@(negedge i_clk);
			n++;
			if (n > 8) begin
				chk(0, 1, "phase stuck");
				end_sim();
			end
		end
		nop_due = is_pc_op(last_op) || (s && is_skip_op(last_op));
		op = nop_due ? ifd_pkg::IFD_OP_NOP : exp_op(x);
		i_instr = x;
		i_skip_true = s;
		@(negedge i_clk);
		chk(o_fetch, 1'b1, "fetch");
		chk(o_nop_cycle, nop_due, "nop flag");
		chk(o_dec.op, op, "op");
		chk(o_dec.is_branch, is_pc_op(op), "branch flag");
		chk(o_dec.is_skip, is_skip_op(op), "skip flag");
		if (nop_due) begin
			chk(o_dec, 0, "forced nop decode");
		end else if (op != ifd_pkg::IFD_OP_BAD) begin
			case (x[13:12])
				2'h0: if (x[11:9] != 3'h0) begin
					chk(o_dec.dest, x[7], "dest");
					chk(o_dec.faddr, x[6:0], "faddr");
				end
				2'h1: begin
					chk(o_dec.faddr, x[6:0], "bit faddr");
					chk(o_dec.bitsel, x[9:7], "bitsel");
				end
				2'h2: chk(o_dec.lit11, x[10:0], "lit11");
				default: chk(o_dec.lit8, x[7:0], "lit8");
			endcase
		end
		last_op = op;
		held = o_dec;
		repeat (3) begin
			@(negedge i_clk);
			chk(o_fetch, 1'b0, "fetch width");
			chk(o_dec, held, "decode held");
		end
		chk(o_phase, 2'h3, "phase count");
	endtask

	// reset, corner words, then random words
	initial begin
		errors = 0;
		total_checks = 0;
		nop_due = 1'b0;
		last_op = ifd_pkg::IFD_OP_NOP;
		i_nrst = 1'b0;
		i_instr = 14'h0000;
		i_skip_true = 1'b0;
		void'($urandom(59018));
		repeat (16) @(negedge i_clk);
		chk({o_phase, o_fetch, o_nop_cycle, o_dec}, 0, "reset state");
		i_nrst = 1'b1;
		foreach (corner[i]) issue(corner[i], 1'b1);
		repeat (400) begin
			w = 14'($urandom);
			if (w[13:8] == 6'h00) w[7] = 1'b1;
			issue(w, 1'($urandom_range(1)));
		end
		end_sim();
	end
endmodule
